// *** hdl/rxfu_decide.sv ***
// combinational follow-up decision from event kind and control bits
`timescale 1ns/10ps
module rxfu_decide (
   rxfu_if.dec ev
);
   always_comb
   begin
      ev.action = rxfu_pkg::RXFU_ACT_NONE;
      ev.nmi = 1'b0;
      if (ev.done)
      begin
         if (ev.is_preamble && !ev.success && ev.by_timer)
         begin
            if (ev.followup[rxfu_pkg::PREA_TF_BIT])
               ev.action = rxfu_pkg::RXFU_ACT_PDOWN;
            else
            begin
               ev.action = rxfu_pkg::RXFU_ACT_HALT;
               ev.nmi = 1'b1;
            end
         end
         else if (ev.is_preamble && !ev.success)
            ev.action = ev.followup[rxfu_pkg::PREA_CF_BIT] ? rxfu_pkg::RXFU_ACT_PDOWN
                                                           : rxfu_pkg::RXFU_ACT_HALT;
         else if (ev.is_preamble)
            // successful preamble detection carries on into data receive
            ev.action = rxfu_pkg::RXFU_ACT_RECEIVE;
         else if (ev.success)
         begin
            // same code, nmi on 11 only when timer started
            unique case (ev.by_timer ? ev.followup[rxfu_pkg::WAKEUP_SEARCH_MODE_TS_HI:rxfu_pkg::WAKEUP_SEARCH_MODE_TS_LO]
                                     : ev.followup[rxfu_pkg::WAKEUP_SEARCH_MODE_CS_HI:rxfu_pkg::WAKEUP_SEARCH_MODE_CS_LO])
               2'h3:
               begin
                  ev.action = rxfu_pkg::RXFU_ACT_RECEIVE;
                  ev.nmi = ev.by_timer;
               end
               2'h2: ev.action = rxfu_pkg::RXFU_ACT_PREAMBLE;
               default:
               begin
                  ev.action = rxfu_pkg::RXFU_ACT_HALT;
                  ev.nmi = 1'b1;
               end
            endcase
         end
         else if (ev.by_timer)
         begin
            if (ev.followup[rxfu_pkg::WAKEUP_SEARCH_MODE_TF_BIT])
               ev.action = rxfu_pkg::RXFU_ACT_PDOWN;
            else
            begin
               ev.action = rxfu_pkg::RXFU_ACT_HALT;
               ev.nmi = 1'b1;
            end
         end
         else
            ev.action = ev.followup[rxfu_pkg::WAKEUP_SEARCH_MODE_CF_BIT] ? rxfu_pkg::RXFU_ACT_PDOWN
                                                           : rxfu_pkg::RXFU_ACT_HALT;
      end
   end
endmodule

// *** hdl/rxfu_if.sv ***
// interface: completion event from top to the decision module
`timescale 1ns/10ps
interface rxfu_if;
   logic done;
   logic is_preamble;
   logic by_timer;
   logic success;
   logic [7:0] followup;
   rxfu_pkg::rxfu_act_t action;
   logic nmi;
   modport top (output done, output is_preamble, output by_timer, output success,
      output followup, input action, input nmi);
   modport dec (input done, input is_preamble, input by_timer, input success,
      input followup, output action, output nmi);
endinterface

// *** hdl/rxfu_pkg.sv ***
// package: register map, field positions, reset values, action codes
package rxfu_pkg;
   localparam logic [7:0] RX_MODE_CONTROL_ADDR = 8'h35;
   localparam logic [7:0] RX_FOLLOWUP_CONTROL_ADDR = 8'h36;
   // rx_followup_control field positions
   localparam int PREA_TF_BIT = 7;
   localparam int PREA_CF_BIT = 6;
   localparam int WAKEUP_SEARCH_MODE_TS_HI = 5;
   localparam int WAKEUP_SEARCH_MODE_TS_LO = 4;
   localparam int WAKEUP_SEARCH_MODE_TF_BIT = 3;
   localparam int WAKEUP_SEARCH_MODE_CS_HI = 2;
   localparam int WAKEUP_SEARCH_MODE_CS_LO = 1;
   localparam int WAKEUP_SEARCH_MODE_CF_BIT = 0;
   // rx_mode_control settle select field
   localparam int SETTLE_HI = 4;
   localparam int SETTLE_LO = 3;
   // reset values; mode control avoids the discouraged settle code
   localparam logic [7:0] FOLLOWUP_RESET = 8'h88;
   localparam logic [7:0] MODE_CONTROL_RESET = 8'h00;
   // settle select code 00 is legal but discouraged
   localparam logic [1:0] SETTLE_RESET = 2'h1;
   localparam logic [4:0] SETTLE_CHIPS_0 = 5'h03;
   localparam logic [4:0] SETTLE_CHIPS_1 = 5'h07;
   localparam logic [4:0] SETTLE_CHIPS_2 = 5'h0f;
   localparam logic [4:0] SETTLE_CHIPS_3 = 5'h1f;
   localparam logic [5:0] PHASE_ERR_0 = 6'h08;
   localparam logic [5:0] PHASE_ERR_1 = 6'h0f;
   localparam logic [5:0] PHASE_ERR_2 = 6'h1e;
   localparam logic [5:0] PHASE_ERR_3 = 6'h3c;
   localparam logic [3:0] TOL_PCT_0 = 4'h8;
   localparam logic [3:0] TOL_PCT_1 = 4'h4;
   localparam logic [3:0] TOL_PCT_2 = 4'h2;
   localparam logic [3:0] TOL_PCT_3 = 4'h1;
   // follow-up action, one-hot
   typedef enum logic [4:0] {
      RXFU_ACT_NONE = 5'h01,
      RXFU_ACT_PDOWN = 5'h02,
      RXFU_ACT_HALT = 5'h04,
      RXFU_ACT_PREAMBLE = 5'h08,
      RXFU_ACT_RECEIVE = 5'h10
   } rxfu_act_t;
endpackage

// *** hdl/rxfu_top.sv ***
// receive follow-up sequencer: registers, mode tracking, action outputs
`timescale 1ns/10ps
module rxfu_top (
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic clk_en_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic search_done_i,
   input wire logic search_is_preamble_i,
   input wire logic search_by_timer_i,
   input wire logic search_success_i,
   output logic [7:0] reg_rdata_o,
   output logic power_down_o,
   output logic halted_o,
   output logic preamble_detect_mode_o,
   output logic data_receive_o,
   output logic nmi_o,
   output logic [1:0] recovery_settle_select_o,
   output logic [4:0] settle_chips_o,
   output logic [5:0] phase_err_deg_o,
   output logic [3:0] tolerance_pct_o
);
   logic [7:0] rx_followup_control_ff;
   logic [7:0] rx_mode_control_ff;
   logic [4:0] nxt_settle_chips;
   logic [5:0] nxt_phase_err;
   logic [3:0] nxt_tol;

   rxfu_if ev ();

   // event inputs come from same-clock logic, so no synchroniser
   assign ev.done = search_done_i;
   assign ev.is_preamble = search_is_preamble_i;
   assign ev.by_timer = search_by_timer_i;
   assign ev.success = search_success_i;
   assign ev.followup = rx_followup_control_ff;

   rxfu_decide u_decide (
      .ev(ev)
   );

   // register writes; other mode-control bits held for the neighbouring logic
   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         rx_followup_control_ff <= rxfu_pkg::FOLLOWUP_RESET;
         rx_mode_control_ff <= rxfu_pkg::MODE_CONTROL_RESET
            | ({6'h00, rxfu_pkg::SETTLE_RESET} << rxfu_pkg::SETTLE_LO);
      end
      else if (clk_en_i && reg_wr_i)
      begin
         if (reg_addr_i == rxfu_pkg::RX_FOLLOWUP_CONTROL_ADDR)
            rx_followup_control_ff <= reg_wdata_i;
         if (reg_addr_i == rxfu_pkg::RX_MODE_CONTROL_ADDR)
            rx_mode_control_ff <= reg_wdata_i;
      end
   end

   // registered read data; unmapped addresses read zero
   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         reg_rdata_o <= 8'h00;
      else if (clk_en_i)
      begin
         if (reg_rd_i && reg_addr_i == rxfu_pkg::RX_FOLLOWUP_CONTROL_ADDR)
            reg_rdata_o <= rx_followup_control_ff;
         else if (reg_rd_i && reg_addr_i == rxfu_pkg::RX_MODE_CONTROL_ADDR)
            reg_rdata_o <= rx_mode_control_ff;
         else
            reg_rdata_o <= 8'h00;
      end
   end

   // settle characteristics lookup
   always_comb
   begin
      unique case (rx_mode_control_ff[rxfu_pkg::SETTLE_HI:rxfu_pkg::SETTLE_LO])
         2'h0:
         begin
            nxt_settle_chips = rxfu_pkg::SETTLE_CHIPS_0;
            nxt_phase_err = rxfu_pkg::PHASE_ERR_0;
            nxt_tol = rxfu_pkg::TOL_PCT_0;
         end
         2'h1:
         begin
            nxt_settle_chips = rxfu_pkg::SETTLE_CHIPS_1;
            nxt_phase_err = rxfu_pkg::PHASE_ERR_1;
            nxt_tol = rxfu_pkg::TOL_PCT_1;
         end
         2'h2:
         begin
            nxt_settle_chips = rxfu_pkg::SETTLE_CHIPS_2;
            nxt_phase_err = rxfu_pkg::PHASE_ERR_2;
            nxt_tol = rxfu_pkg::TOL_PCT_2;
         end
         2'h3:
         begin
            nxt_settle_chips = rxfu_pkg::SETTLE_CHIPS_3;
            nxt_phase_err = rxfu_pkg::PHASE_ERR_3;
            nxt_tol = rxfu_pkg::TOL_PCT_3;
         end
      endcase
   end

   // settle outputs registered so every top output leaves a flop
   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         recovery_settle_select_o <= rxfu_pkg::SETTLE_RESET;
         settle_chips_o <= rxfu_pkg::SETTLE_CHIPS_1;
         phase_err_deg_o <= rxfu_pkg::PHASE_ERR_1;
         tolerance_pct_o <= rxfu_pkg::TOL_PCT_1;
      end
      else if (clk_en_i)
      begin
         recovery_settle_select_o <= rx_mode_control_ff[rxfu_pkg::SETTLE_HI:rxfu_pkg::SETTLE_LO];
         settle_chips_o <= nxt_settle_chips;
         phase_err_deg_o <= nxt_phase_err;
         tolerance_pct_o <= nxt_tol;
      end
   end

   // state after the last completion; holds until the next completion
   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         power_down_o <= 1'b0;
         halted_o <= 1'b0;
         preamble_detect_mode_o <= 1'b0;
         data_receive_o <= 1'b0;
      end
      else if (clk_en_i && search_done_i)
      begin
         power_down_o <= (ev.action == rxfu_pkg::RXFU_ACT_PDOWN);
         halted_o <= (ev.action == rxfu_pkg::RXFU_ACT_HALT);
         preamble_detect_mode_o <= (ev.action == rxfu_pkg::RXFU_ACT_PREAMBLE);
         data_receive_o <= (ev.action == rxfu_pkg::RXFU_ACT_RECEIVE);
      end
   end

   // nmi is a one-cycle pulse; the host owns any latching
   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         nmi_o <= 1'b0;
      else if (clk_en_i)
         nmi_o <= ev.nmi;
   end
endmodule

// *** tb/rxfu_host.sv ***
// host model: strobe-port register master driving at the falling edge
`timescale 1ns/10ps
module rxfu_host (
   input wire logic clk_i,
   input wire logic [7:0] rdata_i,
   output logic wr_o,
   output logic rd_o,
   output logic [7:0] addr_o,
   output logic [7:0] wdata_o
);
   initial
   begin
      {wr_o, rd_o, addr_o, wdata_o} = 18'h0;
   end
   // idle lines show the inverse so a stale value never passes for a live one
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(negedge clk_i);
      {wr_o, addr_o, wdata_o} = {1'b1, a, v};
      @(negedge clk_i);
      {wr_o, addr_o, wdata_o} = {1'b0, ~a, ~v};
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(negedge clk_i);
      {rd_o, addr_o} = {1'b1, a};
      @(negedge clk_i);
      v = rdata_i;
      {rd_o, addr_o} = {1'b0, ~a};
   endtask
endmodule

// *** tb/rxfu_props.sv ***
// checker: follow-up actions and settle lookup seen at the top ports
`timescale 1ns/10ps
module rxfu_props (
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic clk_en_i,
   input wire logic reg_wr_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic search_done_i,
   input wire logic search_is_preamble_i,
   input wire logic search_by_timer_i,
   input wire logic search_success_i,
   input wire logic power_down_o,
   input wire logic halted_o,
   input wire logic preamble_detect_mode_o,
   input wire logic data_receive_o,
   input wire logic nmi_o,
   input wire logic [4:0] settle_chips_o,
   input wire logic [5:0] phase_err_deg_o,
   input wire logic [3:0] tolerance_pct_o
);
   logic [7:0] fu_ff;
   wire go = clk_en_i && search_done_i;
   wire [2:0] k = {search_is_preamble_i, search_by_timer_i, search_success_i};
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);
   // shadow copy, since the checker cannot see the register itself
   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         fu_ff <= 8'h88;
      else if (clk_en_i && reg_wr_i && reg_addr_i == 8'h36)
         fu_ff <= reg_wdata_i;
   end
   chips_top_a: assert property (settle_chips_o == 5'h1f |->
      phase_err_deg_o == 6'h3c && tolerance_pct_o == 4'h1) else $error("settle row 3 wrong");
   chips_low_a: assert property (settle_chips_o == 5'h03 |->
      phase_err_deg_o == 6'h08 && tolerance_pct_o == 4'h8) else $error("settle row 0 wrong");
   settle_wr_a: assert property (clk_en_i && reg_wr_i && reg_addr_i == 8'h35 &&
      reg_wdata_i[4:3] == 2'h3 ##1 clk_en_i |=> settle_chips_o == 5'h1f) else $error("settle late");
   pre_tf_a: assert property (go && k == 3'h6 |=>
      (fu_ff[7] ? power_down_o && !nmi_o : halted_o && nmi_o)) else $error("timer preamble fail");
   pre_cf_a: assert property (go && k == 3'h4 |=>
      (fu_ff[6] ? power_down_o : halted_o && !nmi_o)) else $error("command preamble fail");
   wk_ts_a: assert property (go && k == 3'h3 |=> (fu_ff[5:4] == 2'h2 ?
      preamble_detect_mode_o && !nmi_o : nmi_o && (fu_ff[5] ? data_receive_o : halted_o)))
      else $error("timer wakeup hit");
   wk_tf_a: assert property (go && k == 3'h2 |=>
      (fu_ff[3] ? power_down_o : halted_o && nmi_o)) else $error("timer wakeup fail");
   wk_cs_a: assert property (go && k == 3'h1 |=> (fu_ff[2:1] == 2'h3 ?
      data_receive_o && !nmi_o : fu_ff[2] ? preamble_detect_mode_o : halted_o && nmi_o))
      else $error("command wakeup hit");
   wk_cf_a: assert property (go && k == 3'h0 |=>
      (fu_ff[0] ? power_down_o : halted_o && !nmi_o)) else $error("command wakeup fail");
   pre_hit_a: assert property (go && k[2] && k[0] |=>
      data_receive_o && !nmi_o) else $error("preamble hit");
   cover property (go && k == 3'h3);
   cover property (nmi_o);
   cover property (data_receive_o);
endmodule
bind rxfu_top rxfu_props u_props (.*);

// *** tb/testbench.sv ***
// bench: register access, follow-up actions and settle lookup
`timescale 1ns/10ps
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin errors++; \
   $display("CHECK FAILED %s expected %h seen %h", n, e, a); end end
module testbench;
   logic clk, rst_n, clk_en, done, pre, tim, suc, wr, rd;
   logic pd, hlt, pmode, rx, nmi;
   logic [7:0] addr, wdata, rdata, d;
   logic [1:0] sel;
   logic [4:0] chips;
   logic [5:0] phase;
   logic [3:0] tol;
   int errors = 0;
   int check_count = 0;
   // control byte, {preamble, timer, success}, {pdown, halt, preamble, receive, nmi}
   logic [15:0] tv [16] = '{16'h80d0, 16'h00c9, 16'h4090, 16'h0088, 16'h0069, 16'h1069,
      16'h3063, 16'h2064, 16'h0850, 16'h0049, 16'h0622, 16'h0424, 16'h0229, 16'h0110,
      16'h00a2, 16'hfe08};
   // chips, phase error, tolerance per settle code
   logic [14:0] st [4] = '{15'h0c88, 15'h1cf4, 15'h3de2, 15'h7fc1};
   rxfu_host host (.clk_i(clk), .rdata_i(rdata), .wr_o(wr), .rd_o(rd), .addr_o(addr),
      .wdata_o(wdata));
   rxfu_top DUT (.sys_clk_i(clk), .rst_n_i(rst_n), .clk_en_i(clk_en), .reg_wr_i(wr),
      .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdata), .search_done_i(done),
      .search_is_preamble_i(pre), .search_by_timer_i(tim), .search_success_i(suc),
      .reg_rdata_o(rdata), .power_down_o(pd), .halted_o(hlt), .preamble_detect_mode_o(pmode),
      .data_receive_o(rx), .nmi_o(nmi), .recovery_settle_select_o(sel),
      .settle_chips_o(chips), .phase_err_deg_o(phase), .tolerance_pct_o(tol));
   task automatic give_verdict;
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // hang guard
   initial
   begin
      #100000;
      errors++;
      give_verdict();
   end
   initial
   begin
      {rst_n, clk_en, done, pre, tim, suc} = 6'h00;
      repeat (8) @(negedge clk);
      {rst_n, clk_en} = 2'h3;
      host.rd(8'h36, d);
      `CHK("followup reset", 8'h88, d)
      host.rd(8'h35, d);
      `CHK("mode reset", 8'h08, d)
      host.rd(8'h37, d);
      `CHK("unmapped read", 8'h00, d)
      // every settle code, lookup lands two edges after the write
      for (int i = 0; i < 4; i++)
      begin
         host.wr(8'h35, {3'h0, i[1:0], 3'h0});
         @(negedge clk);
         `CHK("settle code", i[1:0], sel)
         `CHK("settle table", st[i], {chips, phase, tol})
         host.rd(8'h35, d);
         `CHK("mode readback", {3'h0, i[1:0], 3'h0}, d)
      end
      // seven completion kinds (all but a successful timer preamble), each against chosen control codes
      for (int i = 0; i < 16; i++)
      begin
         host.wr(8'h36, tv[i][15:8]);
         {done, pre, tim, suc} = {1'b1, tv[i][7:5]};
         @(negedge clk);
         done = 1'b0;
         `CHK("action", tv[i][4:0], {pd, hlt, pmode, rx, nmi})
         @(negedge clk);
         `CHK("nmi pulse", 1'b0, nmi)
      end
      // a completion while the clock enable is low must be lost
      {clk_en, done, pre, tim, suc} = 5'h0c;
      @(negedge clk);
      {clk_en, done} = 2'h2;
      @(negedge clk);
      `CHK("frozen action", 2'h1, {pd, hlt})
      host.rd(8'h36, d);
      `CHK("followup readback", 8'hfe, d)
      give_verdict();
   end
endmodule
